// *** rtl/phy_mgmt_pkg.sv ***
/*
 package of the indicator-behaviour and page-select register block:
 indices, field positions, reset values, page codes and timing counts.
 assumes a 100 MHz management clock.
*/
package phy_mgmt_pkg;
    localparam int IDX_W = 5;
    localparam int DATA_W = 16;
    localparam int CNT_W = 14;
    localparam int RATE_W = 2;
    localparam int NUM_IND = 4;
    // register indices; the byte address is four times the index
    localparam logic [4:0] IDX_BEHAVIOR = 5'h1E;
    localparam logic [4:0] IDX_PAGE_SEL = 5'h1F;
    localparam logic [4:0] IDX_LOW_LAST = 5'h0F;
    localparam logic [4:0] IDX_EXT_FIRST = 5'h10;
    localparam logic [4:0] IDX_GOOD_CNT = 5'h12;
    localparam logic [4:0] IDX_XOVER = 5'h13;
    localparam logic [4:0] IDX_CTRL3 = 5'h14;
    localparam logic [4:0] IDX_CTRL4 = 5'h17;
    localparam logic [4:0] IDX_DIAG_FIRST = 5'h18;
    localparam logic [4:0] IDX_DIAG_LAST = 5'h1A;
    localparam logic [4:0] IDX_GEN_FIRST = 5'h1D;
    // page codes
    localparam logic [15:0] PAGE_MAIN = 16'h0000;
    localparam logic [15:0] PAGE_EXT1 = 16'h0001;
    localparam logic [15:0] PAGE_EXT2 = 16'h0002;
    localparam logic [15:0] PAGE_RESET = 16'h0000;
    // indicator-behaviour fields
    localparam int BEH_ACT_SEL_BIT = 14;
    localparam int BEH_PULSE_BIT = 12;
    localparam int BEH_RATE_LSB = 10;
    localparam int BEH_STRETCH_LSB = 5;
    localparam int BEH_COMB_LSB = 0;
    localparam logic [15:0] BEH_WMASK = 16'h5DEF;
    localparam logic [15:0] BEH_RESET = 16'h0400;
    localparam int CNT_ACTIVE_BIT = 15;
    // timing: the slowest stretch is sixteen base ticks
    localparam longint CLK_HZ = 100000000;
    localparam longint SLOW_STRETCH_MS = 400;
    localparam longint SLOW_STRETCH_TICKS = 16;
    localparam longint TICK_CYCLES_DEF =
        CLK_HZ / 1000 * SLOW_STRETCH_MS / SLOW_STRETCH_TICKS;
    localparam int TICK_W = 24;
    typedef enum logic [2:0] {
        TGT_MAIN, TGT_PAGE, TGT_BEHAV, TGT_EXT1, TGT_EXT2, TGT_CNT, TGT_NONE
    } target_t;
endpackage

// *** rtl/page_map_if.sv ***
/*
 carrier between the register front end and the page decoder.
 assumes phy_mgmt_pkg is compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
interface page_map_if;
    import phy_mgmt_pkg::*;
    logic [4:0] index;
    logic [15:0] page;
    target_t target;
    logic [3:0] slot;
    modport dec (input index, input page, output target, output slot);
    modport req (output index, output page, input target, input slot);
endinterface
`default_nettype wire

// *** rtl/page_decode.sv ***
/*
 maps a register index and the current page onto a storage target.
 purely combinational; assumes the page word comes from a flip-flop.
*/
`timescale 1ns/1ns
`default_nettype none
module page_decode
    import phy_mgmt_pkg::*;
(
    page_map_if.dec m
);
    // index 31 is the same page-select word on every page
    always_comb begin
        m.slot = 4'(m.index - IDX_EXT_FIRST);
        if (m.index == IDX_PAGE_SEL) begin
            m.target = TGT_PAGE;
        end else if (m.index <= IDX_LOW_LAST) begin
            m.target = TGT_MAIN;
        end else if (m.page == PAGE_MAIN) begin
            m.target = (m.index == IDX_BEHAVIOR) ? TGT_BEHAV : TGT_MAIN;
        end else if (m.page == PAGE_EXT1) begin
            case (m.index)
                IDX_GOOD_CNT: m.target = TGT_CNT;
                IDX_XOVER, IDX_CTRL3, IDX_CTRL4: m.target = TGT_EXT1;
                default: begin
                    if ((m.index >= IDX_DIAG_FIRST &&
                         m.index <= IDX_DIAG_LAST) ||
                        m.index >= IDX_GEN_FIRST) begin
                        m.target = TGT_EXT1;
                    end else begin
                        m.target = TGT_NONE;
                    end
                end
            endcase
        end else if (m.page == PAGE_EXT2) begin
            m.target = TGT_EXT2;
        end else begin
            m.target = TGT_NONE; // reserved page codes reach nothing
        end
    end
endmodule
`default_nettype wire

// *** rtl/indicator_drive.sv ***
/*
 one indicator output: blink or pulse-stretch of the event on top of the
 base state, or the base state alone. assumes tick and phase from the top.
*/
`timescale 1ns/1ns
`default_nettype none
module indicator_drive (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic tick,
    input wire logic blink_phase,
    input wire logic [5:0] stretch_len,
    input wire logic base,
    input wire logic event_in,
    input wire logic stretch_en,
    input wire logic comb_dis,
    output logic out_q
);
    logic [5:0] left_q;
    logic shown;

    // restart on every event so a busy line stays lit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_q <= 6'h00;
        end else if (ce) begin
            if (event_in) begin
                left_q <= stretch_len;
            end else if (tick && left_q != 6'h00) begin
                left_q <= left_q - 6'h01;
            end
        end
    end

    always_comb begin
        shown = stretch_en ? (left_q != 6'h00) : (event_in & blink_phase);
    end

    // the event toggles the base level so it shows with link up or down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 1'b0;
        end else if (ce) begin
            out_q <= comb_dis ? base : (base ^ shown);
        end
    end
endmodule
`default_nettype wire

// *** rtl/phy_led_page_regs.sv ***
/*
 management register block of the phy: indicator-behaviour register,
 page-select register and the paged register space behind it, on apb.
 assumes an apb master on pclk, and line status inputs synchronous
 to pclk. ce low freezes all state and holds pready low.
*/
`timescale 1ns/1ns
`default_nettype none
module phy_led_page_regs
    import phy_mgmt_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter longint TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_up,
    input wire logic activity,
    input wire logic full_duplex,
    input wire logic collision,
    input wire logic good_packet,
    output logic indicator_out_0,
    output logic indicator_out_1,
    output logic indicator_out_2,
    output logic indicator_out_3,
    output logic activity_select,
    output logic pulsing_enable,
    output logic [15:0] page_select
);
    localparam logic [TICK_W-1:0] TICK_LAST =
        TICK_W'(TICK_CYCLES - 1);

    // refuse address widths outside 7..32 and tick counts the divider cannot hold
    if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must lie in 7..32");
    end
    if (TICK_CYCLES < 1 || TICK_CYCLES > (1 << TICK_W)) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    // half blink period in base ticks; stretch is twice this
    function automatic logic [4:0] half_ticks(input logic [1:0] rate);
        half_ticks = 5'h08 >> rate;
    endfunction

    // flag a byte address that is not word aligned or lies above the map
    function automatic logic addr_bad(input logic [ADDR_W-1:0] a);
        addr_bad = (a[1:0] != 2'h0) || ((a >> 7) != '0);
    endfunction

    logic [15:0] behav_q;
    logic [15:0] page_q;
    logic [15:0] main_q [0:29];
    logic [15:0] ext1_q [0:14];
    logic [15:0] ext2_q [0:14];
    logic cnt_active_q;
    logic [CNT_W-1:0] cnt_q;
    logic [31:0] rdata_q;
    logic err_q;
    logic held_q;
    logic [TICK_W-1:0] tick_cnt_q;
    logic tick;
    logic [4:0] phase_cnt_q;
    logic blink_phase_q;
    logic [4:0] half_len;
    logic [5:0] stretch_len;
    logic [1:0] rate;
    logic [4:0] index;
    logic bad;
    logic setup;
    logic done;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic [15:0] rword;
    logic [NUM_IND-1:0] base_vec;
    logic [NUM_IND-1:0] event_vec;
    logic [NUM_IND-1:0] ind_q;

    page_map_if pm ();

    page_decode u_decode (
        .m(pm)
    );

    // apb request decode
    always_comb begin
        index = paddr[6:2];
        bad = addr_bad(paddr);
        wdata = pwdata[15:0];
        setup = psel && ce && !held_q;
        done = psel && penable && pready;
        wr = done && pwrite && !err_q;
        rd = done && !pwrite && !err_q;
        pm.index = index;
        pm.page = page_q;
    end

    // answer only once read data has been caught; ce low stalls it
    assign pready = psel && penable && ce && held_q;
    assign pslverr = err_q;
    assign prdata = rdata_q;

    // read mux by decoded target
    always_comb begin
        rword = 16'h0000;
        case (pm.target)
            TGT_MAIN: rword = main_q[index];
            TGT_PAGE: rword = page_q;
            TGT_BEHAV: rword = behav_q & BEH_WMASK;
            TGT_EXT1: rword = ext1_q[pm.slot];
            TGT_EXT2: rword = ext2_q[pm.slot];
            TGT_CNT: rword = {cnt_active_q, 1'b0, cnt_q};
            TGT_NONE: rword = 16'h0000;
            default: rword = 16'h0000;
        endcase
    end

    // read data, error and hold flag are caught in the first ce cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h00000000;
            err_q <= 1'b0;
            held_q <= 1'b0;
        end else if (ce) begin
            if (done) begin
                held_q <= 1'b0;
            end else if (setup) begin
                held_q <= 1'b1;
                err_q <= bad;
                rdata_q <= bad ? 32'h00000000 : {16'h0000, rword};
            end
        end
    end

    // indicator-behaviour register, reserved bits kept zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            behav_q <= BEH_RESET;
        end else if (ce) begin
            if (wr && pm.target == TGT_BEHAV) begin
                behav_q <= wdata & BEH_WMASK;
            end
        end
    end

    // page-select word; other codes are stored but reach nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_q <= PAGE_RESET;
        end else if (ce) begin
            if (wr && pm.target == TGT_PAGE) begin
                page_q <= wdata;
            end
        end
    end

    // main-page words other than the behaviour register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 30; i++) begin
                main_q[i] <= 16'h0000;
            end
        end else if (ce) begin
            if (wr && pm.target == TGT_MAIN) begin
                main_q[index] <= wdata;
            end
        end
    end

    // extended page one control words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 15; i++) begin
                ext1_q[i] <= 16'h0000;
            end
        end else if (ce) begin
            if (wr && pm.target == TGT_EXT1) begin
                ext1_q[pm.slot] <= wdata;
            end
        end
    end

    // extended page two words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 15; i++) begin
                ext2_q[i] <= 16'h0000;
            end
        end else if (ce) begin
            if (wr && pm.target == TGT_EXT2) begin
                ext2_q[pm.slot] <= wdata;
            end
        end
    end

    // good-packet counter clears on read; a packet in the read cycle
    // starts the new count; one that lands after the count is caught and before the read completes is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            cnt_active_q <= 1'b0;
        end else if (ce) begin
            if (rd && pm.target == TGT_CNT) begin
                cnt_q <= good_packet ? CNT_W'(1) : '0;
                cnt_active_q <= good_packet;
            end else if (good_packet) begin
                if (cnt_q != '1) begin
                    cnt_q <= cnt_q + CNT_W'(1); // saturates, no wrap
                end
                cnt_active_q <= 1'b1;
            end
        end
    end

    // base tick divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= '0;
        end else if (ce) begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + TICK_W'(1);
        end
    end
    assign tick = (tick_cnt_q == TICK_LAST);

    always_comb begin
        rate = behav_q[BEH_RATE_LSB +: RATE_W];
        half_len = half_ticks(rate);
        stretch_len = {half_ticks(rate), 1'b0};
    end

    // blink phase toggles every half period; a rate change that lands
    // below the running count restarts the half period at the next tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_cnt_q <= 5'h00;
            blink_phase_q <= 1'b0;
        end else if (ce && tick) begin
            if (phase_cnt_q + 5'h01 >= half_len) begin
                phase_cnt_q <= 5'h00;
                blink_phase_q <= ~blink_phase_q;
            end else begin
                phase_cnt_q <= phase_cnt_q + 5'h01;
            end
        end
    end

    // outputs 0..2 show link with activity, output 3 duplex with collision
    always_comb begin
        base_vec = {full_duplex, link_up, link_up, link_up};
        event_vec = {collision, activity, activity, activity};
    end

    for (genvar g = 0; g < NUM_IND; g++) begin : g_ind
        indicator_drive u_drive (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .tick(tick),
            .blink_phase(blink_phase_q),
            .stretch_len(stretch_len),
            .base(base_vec[g]),
            .event_in(event_vec[g]),
            .stretch_en(behav_q[BEH_STRETCH_LSB + g]),
            .comb_dis(behav_q[BEH_COMB_LSB + g]),
            .out_q(ind_q[g])
        );
    end

    assign indicator_out_0 = ind_q[0];
    assign indicator_out_1 = ind_q[1];
    assign indicator_out_2 = ind_q[2];
    assign indicator_out_3 = ind_q[3];
    assign activity_select = behav_q[BEH_ACT_SEL_BIT];
    assign pulsing_enable = behav_q[BEH_PULSE_BIT];
    assign page_select = page_q;
endmodule
`default_nettype wire

// *** bench/phy_led_page_props.sv ***
/*
 port assertions of the indicator and page register block.
 assumes one clock pclk and reset presetn, active low.
*/
`timescale 1ns/1ns
`default_nettype none
module phy_led_page_props #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic link_up,
    input wire logic indicator_out_0,
    input wire logic activity_select,
    input wire logic pulsing_enable,
    input wire logic [15:0] page_select
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic done;
    logic [3:0] comb_q;
    // a completed write
    assign done = psel && penable && pready && pwrite;
    // mirror of the combination bits; only page 0 reaches them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comb_q <= 4'h0;
        end else if (done && paddr[7:0] == 8'h78 && page_select == 16'h0) begin
            comb_q <= pwdata[3:0];
        end
    end
    reset_values_a: assert property ($rose(presetn) |->
        page_select == 16'h0000 && !activity_select && !pulsing_enable)
        else $error("page or behaviour not at reset value");
    page_write_a: assert property (done && paddr[7:0] == 8'h7C |=>
        page_select == $past(pwdata[15:0])) else $error("page not written");
    page_hold_a: assert property (!(done && paddr[7:0] == 8'h7C) |=>
        $stable(page_select)) else $error("page word moved");
    behav_write_a: assert property (done && paddr[7:0] == 8'h78 &&
        page_select == 16'h0 |=> activity_select == $past(pwdata[14]) &&
        pulsing_enable == $past(pwdata[12])) else $error("bits 14/12 lost");
    bad_addr_a: assert property (psel && penable && pready &&
        paddr[1:0] != 2'b00 |-> pslverr) else $error("no error response");
    upper_zero_a: assert property (psel && penable |->
        prdata[31:16] == 16'h0000) else $error("read upper half not zero");
    zero_wait_a: assert property (psel && !penable && ce ##1
        penable && ce |-> pready) else $error("access not answered");
    comb_off_a: assert property ($past(comb_q[0]) && $past(ce) |->
        indicator_out_0 == $past(link_up)) else $error("output not base");
endmodule
bind phy_led_page_regs phy_led_page_props #(.ADDR_W(ADDR_W)) u_props (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_up(link_up), .indicator_out_0(indicator_out_0),
    .activity_select(activity_select), .pulsing_enable(pulsing_enable),
    .page_select(page_select));
`default_nettype wire

// *** bench/mgmt_host.sv ***
/*
 management host model: apb master doing one register transfer a call.
 assumes pclk from the bench; the slave may add wait states.
*/
`timescale 1ns/1ns
`default_nettype none
module mgmt_host (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // setup, then access held until pready is seen high at a rising edge;
    // answer taken at that same edge, before any update lands
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [15:0] d, output logic [15:0] q,
            output logic err, output logic late);
        int n;
        logic r;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {~d, d}; // upper half must be ignored
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
            r = pready;
            q = prdata[15:0];
            err = pslverr;
        end while (r !== 1'b1 && n < 50);
        late = (r !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~pwdata; // released data does not hold its value
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// *** bench/phy_led_behavior_and_page_select_tb.sv ***
/*
 self-checking bench of the indicator and page register block.
 assumes the host model drives apb; base tick cut to four cycles.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module phy_led_behavior_and_page_select_tb;
    localparam int TK = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, act_sel, pul_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic link_up = 1'b0, activity = 1'b0, full_duplex = 1'b0;
    logic collision = 1'b0, good_packet = 1'b0;
    logic [3:0] ind;
    logic [3:0] snap;
    logic [15:0] page;
    logic [31:0] seed = 32'h5B7D4A72;
    logic [15:0] sh [3][32];
    logic [7:0] bad [3] = '{8'h81, 8'h80, 8'hFE};
    int miscompares = 0;
    int num_checks = 0;
    always #5 pclk = ~pclk;
    phy_led_page_regs #(.TICK_CYCLES(TK)) dut (.pclk(pclk),
        .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_up(link_up),
        .activity(activity), .full_duplex(full_duplex),
        .collision(collision), .good_packet(good_packet),
        .indicator_out_0(ind[0]), .indicator_out_1(ind[1]),
        .indicator_out_2(ind[2]), .indicator_out_3(ind[3]),
        .activity_select(act_sel), .pulsing_enable(pul_en),
        .page_select(page));
    mgmt_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    // repeatable random source
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // writable bits per page and index; page 1 has gaps and a counter
    function automatic logic [15:0] wm(input int p, input int i);
        if (i < 16 || p == 0) return (i == 30) ? 16'h5DEF : 16'hFFFF;
        if (p == 2) return 16'hFFFF;
        return (i inside {19, 20, [23:26], 29, 30}) ? 16'hFFFF : 16'h0;
    endfunction
    task automatic results;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic rw(input logic w, input logic [7:0] a,
            input logic [15:0] d, output logic [15:0] q, output logic e);
        logic t;
        host.xfer(w, a, d, q, e, t);
        if (t) begin
            miscompares++;
            results();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic e;
        rw(1'b1, a, d, q, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] x);
        logic [15:0] q;
        logic e;
        rw(1'b0, a, 16'h0, q, e);
        `CHK(q, x)
    endtask
    // main sequence
    initial begin
        logic [15:0] q;
        logic e;
        foreach (sh[p, i]) sh[p][i] = 16'h0;
        sh[0][30] = 16'h0400;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(8'h78, 16'h0400);
        rd_chk(8'h7C, 16'h0000);
        for (int p = 0; p < 3; p++) begin
            wr(8'h7C, 16'(p));
            for (int i = 0; i < 31; i++) begin
                seed = xs(seed);
                wr(8'(i * 4), seed[15:0]);
                sh[(i < 16) ? 0 : p][i] = seed[15:0] & wm(p, i);
            end
        end
        for (int p = 0; p < 3; p++) begin
            wr(8'h7C, 16'(p));
            rd_chk(8'h7C, 16'(p));
            for (int i = 0; i < 31; i++)
                rd_chk(8'(i * 4), sh[(i < 16) ? 0 : p][i]);
        end
        // reserved page code: paged indices read zero, writes lost
        wr(8'h7C, 16'h0005);
        for (int i = 16; i < 31; i++) begin
            wr(8'(i * 4), 16'hFFFF);
            rd_chk(8'(i * 4), 16'h0000);
        end
        rd_chk(8'h7C, 16'h0005);
        wr(8'h7C, 16'h0000);
        for (int i = 16; i < 31; i++)
            rd_chk(8'(i * 4), sh[0][i]);
        foreach (bad[k]) begin
            rw(1'b1, bad[k], 16'hFFFF, q, e);
            rw(1'b0, bad[k], 16'h0, q, e);
            `CHK({e, q}, 17'h10000)
        end
        rd_chk(8'h00, sh[0][0]);
        wr(8'h78, 16'hFFFF);
        rd_chk(8'h78, 16'h5DEF);
        `CHK({act_sel, pul_en}, 2'b11)
        // combination off: random line state, outputs show base only
        wr(8'h78, 16'h000F);
        repeat (40) begin
            @(posedge pclk);
            seed = xs(seed);
            {link_up, activity, full_duplex, collision} <= seed[3:0];
        end
        @(posedge pclk);
        @(negedge pclk);
        `CHK(ind[3], full_duplex)
        // one activity event, stretched on output 0 at each rate
        for (int r = 0; r < 4; r++) begin
            wr(8'h78, 16'(r << 10) | 16'h0020);
            {link_up, activity} <= 2'b00;
            repeat (80) @(posedge pclk);
            activity <= 1'b1;
            @(posedge pclk);
            activity <= 1'b0;
            repeat ((16 >> r) * TK - TK - 1) @(posedge pclk);
            @(negedge pclk);
            `CHK(ind[0], 1'b1)
            repeat (2 * TK + 2) @(posedge pclk);
            @(negedge pclk);
            `CHK(ind[0], 1'b0)
        end
        // ce low stalls a read and freezes the outputs; link change unseen
        fork
            rd_chk(8'h78, 16'h0C20);
            begin
                @(posedge pclk);
                ce <= 1'b0;
                link_up <= 1'b1;
                @(negedge pclk);
                snap = ind;
                repeat (3) @(posedge pclk);
                @(negedge pclk);
                `CHK(ind, snap)
                ce <= 1'b1;
            end
        join
        wr(8'h7C, 16'h0001);
        repeat (3) begin
            @(posedge pclk);
            good_packet <= 1'b1;
            @(posedge pclk);
            good_packet <= 1'b0;
        end
        rd_chk(8'h48, 16'h8003);
        rd_chk(8'h48, 16'h0000);
        results();
    end
endmodule
`default_nettype wire
